// [verilog/embedded_nonvolatile_array_ctrl.sv]
`timescale 1ns/1ps

module embedded_nonvolatile_array_ctrl
  import embedded_nonvolatile_array_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire embedded_nonvolatile_array_req_t req,
  input wire logic freq_wr,
  input wire logic [7:0] freq_wdata,
  input wire logic [EMBEDDED_NONVOLATILE_ARRAY_NUM_REGIONS-1:0] region_rd_prot,
  input wire logic [EMBEDDED_NONVOLATILE_ARRAY_NUM_REGIONS-1:0] region_wr_prot,
  input wire logic sc_prog_req,
  input wire logic sc_wr_valid,
  input wire logic [31:0] sc_wr_addr,
  input wire logic [31:0] sc_wr_data,
  input wire logic cpu_core_hold_reset_n,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  output logic fetch_ready,
  output logic [31:0] fetch_data,
  output embedded_nonvolatile_array_status_t status,
  output logic done,
  output logic [31:0] rdata,
  output logic [7:0] nvm_frequency_range_setting,
  output logic sc_own,
  output logic [EMBEDDED_NONVOLATILE_ARRAY_NUM_PAGES-1:0] page_locked
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [31:0] mem [0:(1<<EMBEDDED_NONVOLATILE_ARRAY_WORD_BITS)-1];
  embedded_nonvolatile_array_state_t state;
  logic [7:0] cnt;
  embedded_nonvolatile_array_req_t cur;
  logic wp_seen;

  // ----------------------------------------------------------------
  // region checks, one instance per region
  // ----------------------------------------------------------------
  wire logic [EMBEDDED_NONVOLATILE_ARRAY_NUM_REGIONS-1:0] rd_blk;
  wire logic [EMBEDDED_NONVOLATILE_ARRAY_NUM_REGIONS-1:0] wr_blk;

  genvar gi;
  generate
    for (gi = 0; gi < EMBEDDED_NONVOLATILE_ARRAY_NUM_REGIONS; gi++)
    begin : g_region
      embedded_nonvolatile_array_region_check #(
        .BASE(EMBEDDED_NONVOLATILE_ARRAY_REGION_BASE0 + 32'(gi << EMBEDDED_NONVOLATILE_ARRAY_REGION_SHIFT))
      ) u_chk (
        .addr(cur.addr),
        .rd_prot(region_rd_prot[gi]),
        .wr_prot(region_wr_prot[gi]),
        .rd_block(rd_blk[gi]),
        .wr_block(wr_blk[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // decode of the command in flight
  // ----------------------------------------------------------------
  wire logic [EMBEDDED_NONVOLATILE_ARRAY_WORD_BITS-1:0] cur_word;
  wire logic [2:0] cur_page;
  wire logic [EMBEDDED_NONVOLATILE_ARRAY_WORD_BITS-1:0] fetch_word;
  wire logic in_reserved;
  wire logic wr_denied;
  wire logic freq_low;
  wire logic rd_denied;
  wire logic unlock_denied;
  wire logic op_end;
  wire logic false_pt;
  wire logic take;
  wire logic fetch_go;

  assign cur_word = cur.addr[EMBEDDED_NONVOLATILE_ARRAY_WORD_BITS+1:2];
  assign cur_page = cur.addr[EMBEDDED_NONVOLATILE_ARRAY_PAGE_LSB+2:EMBEDDED_NONVOLATILE_ARRAY_PAGE_LSB];
  assign fetch_word = fetch_addr[EMBEDDED_NONVOLATILE_ARRAY_WORD_BITS+1:2];
  // reserved for the system controller, never writable by users
  assign in_reserved = (cur.addr >= EMBEDDED_NONVOLATILE_ARRAY_RSV_LO) && (cur.addr <= EMBEDDED_NONVOLATILE_ARRAY_RSV_HI);
  assign wr_denied = in_reserved | (|wr_blk) | page_locked[cur_page];
  // writes need the raised setting; reads ignore it
  assign freq_low = (nvm_frequency_range_setting != EMBEDDED_NONVOLATILE_ARRAY_FREQ_WRITE);
  assign rd_denied = |rd_blk;
  // any write protection ever seen blocks page unlocks; lock commands still set locks
  assign unlock_denied = wp_seen | (|region_wr_prot);
  assign op_end = (state == EMBEDDED_NONVOLATILE_ARRAY_ST_BUSY) && (cnt == EMBEDDED_NONVOLATILE_ARRAY_OP_LAST);
  assign false_pt = (state == EMBEDDED_NONVOLATILE_ARRAY_ST_BUSY) && (cnt == EMBEDDED_NONVOLATILE_ARRAY_FALSE_CNT);
  // a request is only taken while idle and not owned
  assign take = (state == EMBEDDED_NONVOLATILE_ARRAY_ST_IDLE) && req_valid && !sc_prog_req;
  // fetch is withheld while owned; the core keeps its address meanwhile
  assign fetch_go = fetch_valid && cpu_core_hold_reset_n && !sc_own && !fetch_ready;

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state <= EMBEDDED_NONVOLATILE_ARRAY_ST_IDLE;
      cnt <= 8'h00;
      cur <= '0;
      sc_own <= 1'b0;
    end
    else
    begin
      unique case (state)
        EMBEDDED_NONVOLATILE_ARRAY_ST_IDLE:
        begin
          if (sc_prog_req)
          begin
            state <= EMBEDDED_NONVOLATILE_ARRAY_ST_OWNED;
            sc_own <= 1'b1;
          end
          else if (take)
          begin
            state <= EMBEDDED_NONVOLATILE_ARRAY_ST_BUSY;
            cur <= req;
            cnt <= 8'h00;
          end
        end
        EMBEDDED_NONVOLATILE_ARRAY_ST_BUSY:
        begin
          cnt <= cnt + 8'h01;
          if (op_end)
          begin
            state <= EMBEDDED_NONVOLATILE_ARRAY_ST_IDLE;
          end
        end
        EMBEDDED_NONVOLATILE_ARRAY_ST_OWNED:
        begin
          // hand back once programming is over
          if (!sc_prog_req)
          begin
            state <= EMBEDDED_NONVOLATILE_ARRAY_ST_IDLE;
            sc_own <= 1'b0;
          end
        end
        default:
        begin
          state <= EMBEDDED_NONVOLATILE_ARRAY_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status and completion: ready drops on take, rises falsely for one
  // cycle early in the operation, then for real at the end and holds until the
  // next take; every status field lives here so the word has one driver
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      status.ready <= 1'b1;
      done <= 1'b0;
      rdata <= 32'h0;
      status.protected_page_write_error <= 1'b0;
      status.freq_error <= 1'b0;
      status.rd_prot_error <= 1'b0;
      page_locked <= '0;
    end
    else
    begin
      done <= op_end;
      if (take)
      begin
        status.ready <= 1'b0;
      end
      else if (false_pt)
      begin
        status.ready <= 1'b1;
      end
      else if (op_end)
      begin
        status.ready <= 1'b1;
      end
      else if (state == EMBEDDED_NONVOLATILE_ARRAY_ST_BUSY)
      begin
        status.ready <= 1'b0;
      end
      if (op_end)
      begin
        status.protected_page_write_error <= 1'b0;
        status.freq_error <= 1'b0;
        status.rd_prot_error <= 1'b0;
        unique case (cur.cmd)
          EMBEDDED_NONVOLATILE_ARRAY_CMD_READ:
          begin
            rdata <= rd_denied ? 32'h0 : mem[cur_word];
            status.rd_prot_error <= rd_denied;
          end
          EMBEDDED_NONVOLATILE_ARRAY_CMD_WRITE:
          begin
            status.protected_page_write_error <= wr_denied;
            status.freq_error <= !wr_denied && freq_low;
          end
          EMBEDDED_NONVOLATILE_ARRAY_CMD_LOCK:
          begin
            page_locked[cur_page] <= 1'b1;
          end
          EMBEDDED_NONVOLATILE_ARRAY_CMD_UNLOCK:
          begin
            if (!unlock_denied)
            begin
              page_locked[cur_page] <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // array writes: user write at completion, or the system controller
  // while it owns the array (it may also fill the reserved range)
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (op_end && cur.cmd == EMBEDDED_NONVOLATILE_ARRAY_CMD_WRITE && !wr_denied && !freq_low)
    begin
      mem[cur_word] <= cur.wdata;
    end
    else if (sc_own && sc_wr_valid)
    begin
      mem[sc_wr_addr[EMBEDDED_NONVOLATILE_ARRAY_WORD_BITS+1:2]] <= sc_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // frequency-range setting and sticky write-protect memory
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      nvm_frequency_range_setting <= EMBEDDED_NONVOLATILE_ARRAY_FREQ_RESET;
      wp_seen <= 1'b0;
    end
    else
    begin
      if (freq_wr)
      begin
        nvm_frequency_range_setting <= freq_wdata;
      end
      // protection cannot be taken back short of a reset
      if (|region_wr_prot)
      begin
        wp_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // processor fetch port: answered one cycle after it is let through;
  // a stalled fetch is simply not answered, so the core retries the
  // same address after release
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      fetch_ready <= 1'b0;
      fetch_data <= 32'h0;
    end
    else
    begin
      fetch_ready <= fetch_go;
      if (fetch_go)
      begin
        fetch_data <= mem[fetch_word];
      end
    end
  end

endmodule // embedded_nonvolatile_array_ctrl

// [verilog/embedded_nonvolatile_array_pkg.sv]
package embedded_nonvolatile_array_pkg;

  // ----------------------------------------------------------------
  // address map and geometry
  // ----------------------------------------------------------------
  localparam logic [31:0] EMBEDDED_NONVOLATILE_ARRAY_RSV_LO = 32'h6003fc80;
  localparam logic [31:0] EMBEDDED_NONVOLATILE_ARRAY_RSV_HI = 32'h6003ffff;
  localparam int EMBEDDED_NONVOLATILE_ARRAY_NUM_REGIONS = 4;
  localparam int EMBEDDED_NONVOLATILE_ARRAY_REGION_SHIFT = 12; // 4 KB regions
  localparam logic [31:0] EMBEDDED_NONVOLATILE_ARRAY_REGION_BASE0 = 32'h6003c000;
  localparam int EMBEDDED_NONVOLATILE_ARRAY_WORD_BITS = 8; // word-address bits; 256 words kept in the model array
  localparam int EMBEDDED_NONVOLATILE_ARRAY_PAGE_LSB = 7; // 32-word pages
  localparam int EMBEDDED_NONVOLATILE_ARRAY_NUM_PAGES = 8;

  // ----------------------------------------------------------------
  // frequency-range setting
  // ----------------------------------------------------------------
  localparam logic [7:0] EMBEDDED_NONVOLATILE_ARRAY_FREQ_RESET = 8'h07;
  localparam logic [7:0] EMBEDDED_NONVOLATILE_ARRAY_FREQ_WRITE = 8'h0f;

  // ----------------------------------------------------------------
  // timing, 25 MHz reference clock
  // ----------------------------------------------------------------
  localparam int EMBEDDED_NONVOLATILE_ARRAY_CLK_NS = 40;
  localparam int EMBEDDED_NONVOLATILE_ARRAY_OP_NS = 2000;
  localparam int EMBEDDED_NONVOLATILE_ARRAY_OP_CYCLES = EMBEDDED_NONVOLATILE_ARRAY_OP_NS / EMBEDDED_NONVOLATILE_ARRAY_CLK_NS;
  localparam int EMBEDDED_NONVOLATILE_ARRAY_FALSE_AT = 2;
  localparam logic [7:0] EMBEDDED_NONVOLATILE_ARRAY_OP_LAST = 8'(EMBEDDED_NONVOLATILE_ARRAY_OP_CYCLES - 1);
  localparam logic [7:0] EMBEDDED_NONVOLATILE_ARRAY_FALSE_CNT = 8'(EMBEDDED_NONVOLATILE_ARRAY_FALSE_AT);

  // ----------------------------------------------------------------
  // commands, states, carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    EMBEDDED_NONVOLATILE_ARRAY_CMD_READ = 2'h0,
    EMBEDDED_NONVOLATILE_ARRAY_CMD_WRITE = 2'h1,
    EMBEDDED_NONVOLATILE_ARRAY_CMD_LOCK = 2'h2,
    EMBEDDED_NONVOLATILE_ARRAY_CMD_UNLOCK = 2'h3
  } embedded_nonvolatile_array_cmd_t;

  typedef enum logic [1:0]
  {
    EMBEDDED_NONVOLATILE_ARRAY_ST_IDLE = 2'h0,
    EMBEDDED_NONVOLATILE_ARRAY_ST_BUSY = 2'h1,
    EMBEDDED_NONVOLATILE_ARRAY_ST_OWNED = 2'h2
  } embedded_nonvolatile_array_state_t;

  typedef struct packed
  {
    embedded_nonvolatile_array_cmd_t cmd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } embedded_nonvolatile_array_req_t;

  typedef struct packed
  {
    logic rd_prot_error;
    logic freq_error;
    logic protected_page_write_error;
    logic ready;
  } embedded_nonvolatile_array_status_t;

endpackage

// [verilog/embedded_nonvolatile_array_region_check.sv]
`timescale 1ns/1ps

// one protected region: flags accesses that its protection bits forbid
module embedded_nonvolatile_array_region_check
  import embedded_nonvolatile_array_pkg::*;
#(
  parameter logic [31:0] BASE = 32'h0
)
(
  input wire logic [31:0] addr,
  input wire logic rd_prot,
  input wire logic wr_prot,
  output logic rd_block,
  output logic wr_block
);

  // ----------------------------------------------------------------
  // match on the upper address bits only
  // ----------------------------------------------------------------
  wire logic hit;
  assign hit = (addr[31:EMBEDDED_NONVOLATILE_ARRAY_REGION_SHIFT] == BASE[31:EMBEDDED_NONVOLATILE_ARRAY_REGION_SHIFT]);
  assign rd_block = hit & rd_prot;
  assign wr_block = hit & wr_prot;

endmodule // embedded_nonvolatile_array_region_check

// [tb/embedded_nonvolatile_array_ctrl_chk.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the array controller
// ----------------------------------------------------------------
module embedded_nonvolatile_array_ctrl_chk
  import embedded_nonvolatile_array_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic sc_prog_req,
  input wire logic cpu_core_hold_reset_n,
  input wire logic fetch_valid,
  input wire logic fetch_ready,
  input wire embedded_nonvolatile_array_status_t status,
  input wire logic done,
  input wire logic sc_own
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic busy;
  logic [7:0] cnt;
  // a request is taken only when idle; the early ready blip does not count as idle
  wire take = req_valid && status.ready && (!busy || done) && !sc_own && !sc_prog_req;
  // mirror of one command from take to completion
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      busy <= 1'b0;
    else if (take)
      busy <= 1'b1;
    else if (done)
      busy <= 1'b0;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || take)
      cnt <= 8'h0;
    else if (busy)
      cnt <= cnt + 8'h1;
  end
  sequence false_blip;
    !status.ready [*3] ##1 status.ready ##1 !status.ready;
  endsequence
  sequence finish;
    ##51 (done && status.ready);
  endsequence
  false_ready_a: assert property (take |=> false_blip)
    else $error("early ready blip wrong");
  busy_low_a: assert property (busy && cnt >= 8'd4 && cnt <= 8'd49 |-> !status.ready)
    else $error("ready high while busy");
  real_ready_a: assert property (take |-> finish)
    else $error("completion not at cycle 51");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  own_grant_a: assert property (sc_prog_req && !sc_own && !busy |=> sc_own)
    else $error("ownership not granted");
  own_release_a: assert property (sc_own && !sc_prog_req |=> !sc_own)
    else $error("ownership not released");
  fetch_stall_a: assert property (sc_own && $past(sc_own) |-> !fetch_ready)
    else $error("fetch answered while owned");
  fetch_answer_a: assert property (fetch_valid && cpu_core_hold_reset_n && !sc_own
    && !fetch_ready |=> fetch_ready ##1 !fetch_ready)
    else $error("fetch answer wrong");
  core_hold_a: assert property (!cpu_core_hold_reset_n |=> !fetch_ready)
    else $error("fetch answered in core reset");
endmodule // embedded_nonvolatile_array_ctrl_chk

bind embedded_nonvolatile_array_ctrl embedded_nonvolatile_array_ctrl_chk u_port_chk (.ref_clk, .nrst, .req_valid, .sc_prog_req,
  .cpu_core_hold_reset_n, .fetch_valid, .fetch_ready, .status, .done, .sc_own);

// [tb/embedded_nonvolatile_array_cpu_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// processor fetching code word by word from the array
// ----------------------------------------------------------------
module embedded_nonvolatile_array_cpu_model
  import embedded_nonvolatile_array_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [31:0] fetch_addr,
  output logic [15:0] served
);
  logic [31:0] pc;
  // idle address lines show the inverse so a stale value cannot pass
  assign fetch_addr = fetch_valid ? pc : ~pc;
  // the address holds until answered, however long the stall lasts
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      fetch_valid <= 1'b0;
      pc <= 32'h0;
      served <= 16'h0;
    end
    else
    begin
      // a pending fetch is only dropped once it has been answered
      fetch_valid <= go | (fetch_valid & !fetch_ready);
      if (fetch_ready)
      begin
        pc <= pc + 32'h4;
        served <= served + 16'h1;
      end
    end
  end
endmodule // embedded_nonvolatile_array_cpu_model

// [tb/embedded_nonvolatile_array_access_and_protection_tb.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// array controller bench
// ----------------------------------------------------------------
module embedded_nonvolatile_array_access_and_protection_tb;
  import embedded_nonvolatile_array_pkg::*;
  localparam embedded_nonvolatile_array_cmd_t RD = EMBEDDED_NONVOLATILE_ARRAY_CMD_READ;
  localparam embedded_nonvolatile_array_cmd_t WR = EMBEDDED_NONVOLATILE_ARRAY_CMD_WRITE;
  localparam embedded_nonvolatile_array_cmd_t LK = EMBEDDED_NONVOLATILE_ARRAY_CMD_LOCK;
  localparam embedded_nonvolatile_array_cmd_t UL = EMBEDDED_NONVOLATILE_ARRAY_CMD_UNLOCK;
  logic ref_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, freq_wr = 1'b0, sc_prog_req = 1'b0;
  logic sc_wr_valid = 1'b0, cpu_core_hold_reset_n = 1'b1, go = 1'b0;
  embedded_nonvolatile_array_req_t req = '0;
  logic [7:0] freq_wdata = 8'h0;
  logic [EMBEDDED_NONVOLATILE_ARRAY_NUM_REGIONS-1:0] region_rd_prot = '0, region_wr_prot = '0;
  logic [31:0] sc_wr_addr = 32'h0, sc_wr_data = 32'h0;
  logic fetch_valid, fetch_ready, done, sc_own;
  logic [31:0] fetch_addr, fetch_data, rdata;
  logic [7:0] nvm_frequency_range_setting, page_locked;
  logic [15:0] served;
  embedded_nonvolatile_array_status_t status;
  int failures = 0, tests_run = 0, cycles = 0;
  embedded_nonvolatile_array_ctrl uut (.ref_clk, .nrst, .req_valid, .req, .freq_wr, .freq_wdata, .region_rd_prot,
    .region_wr_prot, .sc_prog_req, .sc_wr_valid, .sc_wr_addr, .sc_wr_data,
    .cpu_core_hold_reset_n, .fetch_valid, .fetch_addr, .fetch_ready, .fetch_data, .status,
    .done, .rdata, .nvm_frequency_range_setting, .sc_own, .page_locked);
  embedded_nonvolatile_array_cpu_model cpu (.ref_clk, .nrst, .go, .fetch_ready, .fetch_valid, .fetch_addr, .served);
  // 25 MHz reference
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // one command, then poll ready until it reads set twice in a row: a lone
  // high read is the early false rise, so only the pair marks completion
  task automatic cmd(input embedded_nonvolatile_array_cmd_t c, input logic [31:0] a, d, input logic [3:0] st);
    int n;
    int hits;
    logic seen_done;
    req = '{cmd: c, addr: a, wdata: d};
    req_valid = 1'b1;
    step(1);
    req_valid = 1'b0;
    n = 0;
    hits = 0;
    seen_done = 1'b0;
    while (hits < 2 && n < 60)
    begin
      hits = (status.ready === 1'b1) ? hits + 1 : 0;
      if (hits == 1)
        seen_done = done;
      if (hits < 2)
      begin
        step(1);
        n++;
      end
    end
    chk(32'(EMBEDDED_NONVOLATILE_ARRAY_OP_CYCLES + 1), 32'(n));
    chk(32'h1, 32'(seen_done));
    chk(32'(st), 32'(status));
  endtask
  task automatic setf(input logic [7:0] v);
    freq_wdata = v;
    freq_wr = 1'b1;
    step(1);
    freq_wr = 1'b0;
  endtask
  task automatic t_freq;
    cmd(WR, 32'h60000010, 32'ha5, 4'h5);
    setf(EMBEDDED_NONVOLATILE_ARRAY_FREQ_WRITE);
    chk(32'(EMBEDDED_NONVOLATILE_ARRAY_FREQ_WRITE), 32'(nvm_frequency_range_setting));
    cmd(WR, 32'h60000010, 32'ha5, 4'h1);
    setf(EMBEDDED_NONVOLATILE_ARRAY_FREQ_RESET);
    cmd(RD, 32'h60000010, 32'h0, 4'h1);
    chk(32'ha5, rdata);
    $display("frequency test done");
  endtask
  task automatic t_rsv;
    setf(EMBEDDED_NONVOLATILE_ARRAY_FREQ_WRITE);
    cmd(WR, 32'h60000080, 32'h77, 4'h1);
    cmd(WR, EMBEDDED_NONVOLATILE_ARRAY_RSV_LO, 32'h1, 4'h3);
    cmd(WR, EMBEDDED_NONVOLATILE_ARRAY_RSV_HI - 32'h3, 32'h1, 4'h3);
    cmd(WR, EMBEDDED_NONVOLATILE_ARRAY_RSV_LO - 32'h4, 32'h3c, 4'h1);
    cmd(RD, EMBEDDED_NONVOLATILE_ARRAY_RSV_LO - 32'h4, 32'h0, 4'h1);
    chk(32'h3c, rdata);
    // this word shares its array slot with the refused write; it must be intact
    cmd(RD, 32'h60000080, 32'h0, 4'h1);
    chk(32'h77, rdata);
    $display("reserved range test done");
  endtask
  task automatic t_lock;
    cmd(LK, 32'h6003c080, 32'h0, 4'h1);
    chk(32'h2, 32'(page_locked));
    cmd(WR, 32'h6003c080, 32'h1, 4'h3);
    cmd(UL, 32'h6003c080, 32'h0, 4'h1);
    chk(32'h0, 32'(page_locked));
    region_rd_prot = 4'h1;
    cmd(RD, 32'h6003c000, 32'h0, 4'h9);
    chk(32'h0, rdata);
    region_rd_prot = 4'h0;
    cmd(LK, 32'h6003c080, 32'h0, 4'h1);
    region_wr_prot = 4'h2;
    cmd(WR, 32'h6003d000, 32'h1, 4'h3);
    region_wr_prot = 4'h0;
    cmd(UL, 32'h6003c080, 32'h0, 4'h1);
    chk(32'h2, 32'(page_locked));
    $display("protection test done");
  endtask
  // processor stalls while the controller owns the array, then resumes in place
  task automatic t_own;
    logic [15:0] n;
    int i;
    go = 1'b1;
    step(6);
    sc_prog_req = 1'b1;
    step(3);
    chk(32'h1, 32'(sc_own));
    sc_wr_addr = fetch_addr;
    sc_wr_data = 32'h5a;
    sc_wr_valid = 1'b1;
    step(1);
    sc_wr_valid = 1'b0;
    n = served;
    step(10);
    chk(32'(n), 32'(served));
    sc_prog_req = 1'b0;
    i = 0;
    while (fetch_ready !== 1'b1 && i < 8)
    begin
      step(1);
      i++;
    end
    chk(32'h1, 32'(fetch_ready));
    chk(32'h5a, fetch_data);
    // the core is held in reset before a second programming run
    cpu_core_hold_reset_n = 1'b0;
    step(2);
    n = served;
    sc_prog_req = 1'b1;
    step(6);
    chk(32'(n), 32'(served));
    chk(32'h1, 32'(sc_own));
    sc_prog_req = 1'b0;
    step(2);
    chk(32'h0, 32'(sc_own));
    cpu_core_hold_reset_n = 1'b1;
    go = 1'b0;
    $display("ownership test done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, well above the roughly 870 cycles of the run
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      print_verdict();
    end
  end
  initial
  begin
    step(4);
    nrst = 1'b1;
    chk(32'(EMBEDDED_NONVOLATILE_ARRAY_FREQ_RESET), 32'(nvm_frequency_range_setting));
    t_freq();
    t_rsv();
    t_lock();
    t_own();
    print_verdict();
  end
endmodule // embedded_nonvolatile_array_access_and_protection_tb
